// file: shared/evh_pkg.sv
package evh_pkg;
   localparam int NUM_SRC = 8;
   localparam int GRP_SIZE = 4;
   localparam int HIGH_LSB = 4;
   localparam int LOW_MSB = 3;
   localparam int ADDR_W = 6;
   localparam logic [ADDR_W-1:0] OFF_FLAGS = 6'h00;
   localparam logic [ADDR_W-1:0] OFF_ENABLE = 6'h04;
   localparam logic [ADDR_W-1:0] OFF_TOP_CODE = 6'h08;
   localparam logic [ADDR_W-1:0] OFF_SUMMARY = 6'h0c;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 6'h10;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 6'h14;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] TOP_CODE_NONE = 8'hff;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam int SUM_HIGH_BIT = 1;
   localparam int SUM_LOW_BIT = 0;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: hw/edge_flag.sv
`timescale 1ns/10ps
// one event source: edge detect, enable gate, sticky flag
module edge_flag (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic src,
   input wire logic enable,
   input wire logic clear,
   output logic flag_r,
   output logic rise
);
   logic src_prev_r;

   assign rise = src & ~src_prev_r;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         src_prev_r <= 1'b0;
      end else if (clk_en) begin
         src_prev_r <= src;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         flag_r <= 1'b0;
      end else if (clk_en) begin
         // set beats clear when both land together
         if (enable && rise) begin
            flag_r <= 1'b1;
         end else if (clear) begin
            flag_r <= 1'b0;
         end
      end
   end

   a_flag_sets_on_edge: assert property (@(posedge core_clk)
      disable iff (!resetn) clk_en && enable && rise |=> flag_r)
      else $error("enabled edge did not set flag");
   a_flag_holds: assert property (@(posedge core_clk)
      disable iff (!resetn) flag_r && !clear |=> flag_r)
      else $error("flag dropped without clear");
   a_no_set_disabled: assert property (@(posedge core_clk)
      disable iff (!resetn) clk_en && !flag_r && !(enable && rise)
      |=> !flag_r)
      else $error("flag set without enabled edge");
endmodule

// file: hw/cpu_event_handler.sv
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
// Functional notes
// - eight event sources in two groups of four, high and low.
// - flags 7..4 form the high group, flags 3..0 the low group.
// - each group drives one of the two core event inputs.
// - an active source raises a stored flag, not a pass-through.
// - a flag sets only on a rising source edge with its enable one.
// - enable bits are read/write and reset to zero.
// - a flag stays set until a one is written to it; zero is no-op.
// - system reset clears all flags.
// - top code gives the highest set flag number, or 0xff if none.
// - top code reads all ones after reset.
// - summary bit 1 is any high flag, bit 0 any low flag, rest zero.
// - top code and summary follow the stored flags directly.
module cpu_event_handler
   import evh_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [NUM_SRC-1:0] event_src,
   output logic cpu_event_line_a,
   output logic cpu_event_line_b,
   output logic irq,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [7:0] event_flags;
   logic [7:0] event_enable_r;
   logic [7:0] flag_clear;
   logic [7:0] rise;
   logic [7:0] event_top_code;
   logic [7:0] event_level_summary;
   logic high_level_pending;
   logic low_level_pending;
   logic [7:0] irq_status_r;
   logic [7:0] irq_mask_r;
   logic [7:0] new_events;
   logic aw_held_r;
   logic w_held_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_go;
   logic rd_go;
   logic status_rd;
   logic [31:0] rd_word;
   logic rd_ok;

   // ------------------------------------------------------------
   // event sources
   // ------------------------------------------------------------
   // one cell per source
   for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      edge_flag u_flag (
         .core_clk(core_clk),
         .resetn(resetn),
         .clk_en(clk_en),
         .src(event_src[i]),
         .enable(event_enable_r[i]),
         .clear(flag_clear[i]),
         .flag_r(event_flags[i]),
         .rise(rise[i])
      );
   end

   assign new_events = rise & event_enable_r & ~event_flags;

   // ------------------------------------------------------------
   // summaries
   // ------------------------------------------------------------
   assign high_level_pending = |event_flags[NUM_SRC-1:HIGH_LSB];
   assign low_level_pending = |event_flags[LOW_MSB:0];
   assign cpu_event_line_a = high_level_pending;
   assign cpu_event_line_b = low_level_pending;

   always_comb begin
      event_level_summary = 8'h00;
      event_level_summary[SUM_HIGH_BIT] = high_level_pending;
      event_level_summary[SUM_LOW_BIT] = low_level_pending;
   end

   a_summary_zero: assert property (@(posedge core_clk)
      disable iff (!resetn) event_flags == 8'h00
      |-> event_level_summary == 8'h00)
      else $error("summary set with no flag");
   a_codes_follow: assert property (@(posedge core_clk)
      disable iff (!resetn) $stable(event_flags)
      |-> $stable(event_top_code) && $stable(event_level_summary))
      else $error("codes moved without a flag change");

   // scan upward so the highest set flag wins
   always_comb begin
      event_top_code = TOP_CODE_NONE;
      for (int k = 0; k < NUM_SRC; k++) begin
         if (event_flags[k]) begin
            event_top_code = 8'(k);
         end
      end
   end

   // ------------------------------------------------------------
   // write channel
   // ------------------------------------------------------------
   // no beat taken while frozen, else the master would lose it
   assign s_axi_awready = clk_en && !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = clk_en && !w_held_r && !s_axi_bvalid;
   assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         aw_held_r <= 1'b0;
         awaddr_r <= '0;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         w_held_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else if (clk_en) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (clk_en) begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            case (awaddr_r)
               OFF_FLAGS, OFF_ENABLE, OFF_TOP_CODE, OFF_SUMMARY,
               OFF_IRQ_STATUS, OFF_IRQ_MASK: s_axi_bresp <= RESP_OKAY;
               default: s_axi_bresp <= RESP_SLVERR;
            endcase
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // response comes with the register update, never before
   a_write_resp: assert property (@(posedge core_clk)
      disable iff (!resetn) clk_en && wr_go |=> s_axi_bvalid)
      else $error("write response missing");
   a_write_busy: assert property (@(posedge core_clk)
      disable iff (!resetn) s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write channel ready while response pending");
   a_write_slverr: assert property (@(posedge core_clk)
      disable iff (!resetn) clk_en && wr_go && awaddr_r > OFF_IRQ_MASK
      |=> s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");

   // only byte 0 carries register bits
   always_comb begin
      flag_clear = 8'h00;
      if (wr_go && awaddr_r == OFF_FLAGS && wstrb_r[0]) begin
         flag_clear = wdata_r[7:0];
      end
   end

   a_zero_keeps: assert property (@(posedge core_clk)
      disable iff (!resetn) clk_en && (event_flags & ~flag_clear) != 8'h00
      |=> (event_flags & $past(event_flags & ~flag_clear))
      == $past(event_flags & ~flag_clear))
      else $error("flag lost without a one written");
   a_one_clears: assert property (@(posedge core_clk)
      disable iff (!resetn) clk_en && flag_clear != 8'h00
      |=> (event_flags & $past(flag_clear & ~(rise & event_enable_r)))
      == 8'h00)
      else $error("one written did not clear flag");

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         event_enable_r <= ENABLE_RST;
      end else if (clk_en) begin
         if (wr_go && awaddr_r == OFF_ENABLE && wstrb_r[0]) begin
            event_enable_r <= wdata_r[7:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         irq_mask_r <= MASK_RST;
      end else if (clk_en) begin
         if (wr_go && awaddr_r == OFF_IRQ_MASK && wstrb_r[0]) begin
            irq_mask_r <= wdata_r[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   assign s_axi_arready = clk_en && !s_axi_rvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign status_rd = rd_go && s_axi_araddr == OFF_IRQ_STATUS;

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         OFF_FLAGS: rd_word[7:0] = event_flags;
         OFF_ENABLE: rd_word[7:0] = event_enable_r;
         OFF_TOP_CODE: rd_word[7:0] = event_top_code;
         OFF_SUMMARY: rd_word[7:0] = event_level_summary;
         OFF_IRQ_STATUS: rd_word[7:0] = irq_status_r;
         OFF_IRQ_MASK: rd_word[7:0] = irq_mask_r;
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (clk_en) begin
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   a_read_data: assert property (@(posedge core_clk)
      disable iff (!resetn) clk_en && rd_go
      |=> s_axi_rvalid && s_axi_rdata == $past(rd_word))
      else $error("read data not captured");
   a_read_busy: assert property (@(posedge core_clk)
      disable iff (!resetn) s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   a_read_upper: assert property (@(posedge core_clk)
      disable iff (!resetn) s_axi_rvalid
      |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");

   // ------------------------------------------------------------
   // interrupt
   // ------------------------------------------------------------
   // new event beats the read clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         irq_status_r <= 8'h00;
      end else if (clk_en) begin
         irq_status_r <= (status_rd ? 8'h00 : irq_status_r) | new_events;
      end
   end

   assign irq = |(irq_status_r & irq_mask_r);

   a_status_keeps: assert property (@(posedge core_clk)
      disable iff (!resetn) clk_en && !status_rd
      |=> (irq_status_r & $past(irq_status_r)) == $past(irq_status_r))
      else $error("status bit lost without a read");
   a_status_sets: assert property (@(posedge core_clk)
      disable iff (!resetn) clk_en && new_events != 8'h00
      |=> (irq_status_r & $past(new_events)) == $past(new_events))
      else $error("new event missed in status");
   a_status_read: assert property (@(posedge core_clk)
      disable iff (!resetn) clk_en && status_rd
      |=> irq_status_r == $past(new_events))
      else $error("status read did not clear");
   a_irq_masked: assert property (@(posedge core_clk)
      disable iff (!resetn) irq_mask_r == 8'h00 |-> !irq)
      else $error("irq raised with all bits masked");

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_top_code_none: assert property (@(posedge core_clk)
      disable iff (!resetn) event_flags == 8'h00
      |-> event_top_code == TOP_CODE_NONE)
      else $error("top code not all ones with no flag");
   a_top_code_max: assert property (@(posedge core_clk)
      disable iff (!resetn) event_flags != 8'h00
      |-> event_flags[event_top_code[2:0]] && event_top_code < 8'h08
       && (event_flags >> event_top_code[2:0]) == 8'h01)
      else $error("top code not highest set flag");
   a_lines_follow: assert property (@(posedge core_clk)
      disable iff (!resetn) cpu_event_line_a == (|event_flags[7:4])
      && cpu_event_line_b == (|event_flags[3:0]))
      else $error("event lines disagree with flags");
   a_summary_upper: assert property (@(posedge core_clk)
      disable iff (!resetn) event_level_summary[7:2] == 6'h00
      && event_level_summary[1] == cpu_event_line_a
      && event_level_summary[0] == cpu_event_line_b)
      else $error("summary bits wrong");
   a_enable_write: assert property (@(posedge core_clk)
      disable iff (!resetn) clk_en && wr_go && awaddr_r == OFF_ENABLE
      && wstrb_r[0] |=> event_enable_r == $past(wdata_r[7:0]))
      else $error("enable write lost");
   a_clear_one: assert property (@(posedge core_clk)
      disable iff (!resetn) clk_en && flag_clear[0] && !rise[0]
      |=> !event_flags[0])
      else $error("write one did not clear flag");
   a_set_wins: assert property (@(posedge core_clk)
      disable iff (!resetn) clk_en && flag_clear[7] && rise[7]
      && event_enable_r[7] |=> event_flags[7])
      else $error("edge lost against clear");
   a_reset_flags: assert property (@(posedge core_clk)
      !resetn |=> event_flags == 8'h00 && event_top_code == 8'hff)
      else $error("reset did not clear flags");
   a_reset_regs: assert property (@(posedge core_clk)
      !resetn |=> event_enable_r == ENABLE_RST && irq_mask_r == MASK_RST
      && irq_status_r == 8'h00 && !s_axi_bvalid && !s_axi_rvalid)
      else $error("registers not cleared by reset");
   a_frozen: assert property (@(posedge core_clk)
      disable iff (!resetn) !clk_en |=> $stable(event_flags)
      && $stable(event_enable_r) && $stable(irq_status_r))
      else $error("state moved while clock enable low");
endmodule

// file: dv/evt_src_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// peripheral event sources
// ----------------------------------------
// fire gives a two-cycle pulse per bit, level holds a source high;
// only rising edges matter, so pulses are kept short but visible
module evt_src_model (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [7:0] fire,
   input wire logic [7:0] level,
   output logic [7:0] event_src
);
   logic [7:0] p1_r;
   logic [7:0] p2_r;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         p1_r <= 8'h00;
         p2_r <= 8'h00;
      end else begin
         p1_r <= fire;
         p2_r <= p1_r;
      end
   end
   assign event_src = level | p1_r | p2_r;
endmodule

// file: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import evh_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic core_clk = 0;
   logic resetn = 0;
   logic [7:0] fire = 8'h00;
   logic [7:0] level = 8'h00;
   logic [7:0] event_src;
   logic line_a, line_b, irq;
   logic [5:0] awaddr = 6'h00;
   logic [5:0] araddr = 6'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic clk_en = 1;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [31:0] d;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   always #2.5 core_clk = ~core_clk;
   evt_src_model u_src (.core_clk(core_clk), .resetn(resetn),
      .fire(fire), .level(level), .event_src(event_src));
   cpu_event_handler u_dut (.core_clk(core_clk), .resetn(resetn),
      .clk_en(clk_en), .event_src(event_src), .cpu_event_line_a(line_a),
      .cpu_event_line_b(line_b), .irq(irq), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task test_done;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // each channel released on its own handshake edge
   task wr(input logic [5:0] a, input logic [31:0] v);
      @(posedge core_clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge core_clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      r = bresp;
      bready <= 0;
   endtask
   task rd(input logic [5:0] a);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge core_clk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask
   task rdc(input logic [5:0] a, input logic [31:0] e);
      rd(a);
      chk(d, e);
   endtask
   task fire_src(input logic [7:0] m);
      @(posedge core_clk);
      fire <= m;
      @(posedge core_clk);
      fire <= 8'h00;
      repeat (4) @(posedge core_clk);
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         test_done;
      end
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge core_clk);
      resetn <= 1;
      rdc(OFF_FLAGS, 32'h0000_0000);
      rdc(OFF_ENABLE, 32'h0000_0000);
      rdc(OFF_TOP_CODE, 32'h0000_00ff);
      rdc(OFF_SUMMARY, 32'h0000_0000);
      fire_src(8'hff);
      rdc(OFF_FLAGS, 32'h0000_0000);
      wr(OFF_ENABLE, 32'h0000_00ff);
      chk(r, RESP_OKAY);
      rdc(OFF_ENABLE, 32'h0000_00ff);
      // write without byte 0 strobe must leave enables alone
      wstrb <= 4'he;
      wr(OFF_ENABLE, 32'h0000_0000);
      wstrb <= 4'hf;
      rdc(OFF_ENABLE, 32'h0000_00ff);
      for (int i = 0; i < 8; i++) begin
         fire_src(8'h01 << i);
         chk({line_a, line_b}, {i >= 4, i < 4});
         rdc(OFF_TOP_CODE, 32'(i));
         rdc(OFF_SUMMARY, (i >= 4) ? 32'h2 : 32'h1);
         wr(OFF_FLAGS, 32'h0000_00ff);
         rdc(OFF_FLAGS, 32'h0000_0000);
      end
      fire_src(8'h5a);
      rdc(OFF_TOP_CODE, 32'h0000_0006);
      rdc(OFF_SUMMARY, 32'h0000_0003);
      wr(OFF_FLAGS, 32'h0000_0000);
      rdc(OFF_FLAGS, 32'h0000_005a);
      wr(OFF_FLAGS, 32'h0000_0040);
      rdc(OFF_TOP_CODE, 32'h0000_0004);
      // held level: one edge only, no re-set after clearing
      level <= 8'h80;
      repeat (4) @(posedge core_clk);
      rdc(OFF_FLAGS, 32'h0000_009a);
      wr(OFF_FLAGS, 32'h0000_0080);
      rdc(OFF_FLAGS, 32'h0000_001a);
      level <= 8'h00;
      wr(OFF_FLAGS, 32'h0000_00ff);
      rdc(OFF_TOP_CODE, 32'h0000_00ff);
      chk({line_a, line_b}, 32'h0);
      // edge and clearing write land on the same edge
      fork
         wr(OFF_FLAGS, 32'h0000_0080);
         begin
            @(posedge core_clk);
            fire <= 8'h80;
            @(posedge core_clk);
            fire <= 8'h00;
         end
      join
      rdc(OFF_FLAGS, 32'h0000_0080);
      wr(OFF_FLAGS, 32'h0000_0080);
      rdc(OFF_IRQ_STATUS, 32'h0000_00ff);
      rdc(OFF_IRQ_STATUS, 32'h0000_0000);
      wr(OFF_IRQ_MASK, 32'h0000_0001);
      fire_src(8'h02);
      chk(irq, 1'b0);
      fire_src(8'h01);
      chk(irq, 1'b1);
      rdc(OFF_IRQ_STATUS, 32'h0000_0003);
      chk(irq, 1'b0);
      // frozen core must miss a whole source pulse
      clk_en <= 0;
      fire_src(8'h10);
      clk_en <= 1;
      rdc(OFF_FLAGS, 32'h0000_0003);
      wr(6'h18, 32'h0000_00ff);
      chk(r, RESP_SLVERR);
      rdc(6'h18, 32'h0000_0000);
      chk(r, RESP_SLVERR);
      rdc(OFF_IRQ_MASK, 32'h0000_0001);
      // second reset in mid-run with flags set
      @(posedge core_clk);
      resetn <= 0;
      repeat (2) @(posedge core_clk);
      resetn <= 1;
      rdc(OFF_FLAGS, 32'h0000_0000);
      rdc(OFF_TOP_CODE, 32'h0000_00ff);
      rdc(OFF_ENABLE, 32'h0000_0000);
      rdc(OFF_SUMMARY, 32'h0000_0000);
      test_done;
   end
endmodule
